// file: design/dpr_pkg.sv
// constants and carrier types for the dds profile and control registers
package dpr_pkg;

    // register addresses as seen behind the serial control port
    localparam int              ADDR_W     = 5;
    localparam logic [ADDR_W-1:0] ADDR_CTRL  = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_PROF6 = 5'h0c;
    localparam logic [ADDR_W-1:0] ADDR_PROF7 = 5'h0d;

    // profile register layout
    localparam int REG_W    = 64;
    localparam int POW_W    = 14;
    localparam int FTW_W    = 48;
    localparam int PROF_W   = POW_W + FTW_W;

    // control function one layout
    localparam int CTRL_W        = 32;
    localparam int CTRL_STORE_W  = 24;
    localparam int BIT_LOCK_ERR  = 24;
    localparam int BIT_RR_RELOAD = 23;
    localparam int BIT_AC_FREQ   = 22;
    localparam int BIT_AC_PHASE  = 21;
    localparam int BIT_SINE      = 20;
    localparam int BIT_AUTO_SYNC = 3;
    localparam int BIT_SW_SYNC   = 2;
    localparam int BIT_HW_SYNC   = 1;
    localparam logic [CTRL_STORE_W-1:0] CTRL_RESET = 24'h000000;

    // sync clock is the system clock divided by four
    localparam int         SYNC_CNT_W = 2;
    localparam logic [1:0] SYNC_ZERO  = 2'h0;
    localparam logic [1:0] SYNC_LAST  = 2'h3;
    localparam logic [1:0] SYNC_STEP  = 2'h1;
    localparam logic [1:0] SYNC_ADV   = 2'h2;

    // pin input synchroniser lanes
    localparam int         PIN_N    = 3;
    localparam int         PIN_LOCK = 0;
    localparam int         PIN_SYNC = 1;
    localparam int         PIN_UPD  = 2;
    localparam logic [2:0] PIN_INIT = 3'h1;

    // role of the shared lock / sync pin
    typedef enum logic [2:0] {
        PIN_LOCK_OUT    = 3'b001,
        PIN_SYNC_AUTO   = 3'b010,
        PIN_SYNC_MANUAL = 3'b100
    } dpr_pin_mode_e;

    // one profile: phase offset on top, tuning word below
    typedef struct packed {
        logic [POW_W-1:0] phase_offset_word;
        logic [FTW_W-1:0] frequency_tuning_word;
    } dpr_profile_s;

    localparam dpr_profile_s PROF_RESET = 62'h0;

    // one decoded register transaction from the serial port
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
    } dpr_req_s;

endpackage

// file: design/dpr_sync3.sv
// three flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module dpr_sync3 #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // raw pins in, filtered levels out
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_lane
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            // first stage feeds only the second; filter looks at 2 and 3
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    s1_reg <= INIT[g];
                    s2_reg <= INIT[g];
                    s3_reg <= INIT[g];
                    q_o[g] <= INIT[g];
                end else begin
                    s1_reg <= d_i[g];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        q_o[g] <= s3_reg;
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// file: design/dpr_regs.sv
// profile six/seven and control function one register bank
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - profiles are 62 bits: 14-bit phase offset on top, 48-bit tuning word.
// - read-only bit 24 is set whenever the loop loses lock.
// - lock error stays set until a control readback clears it.
// - in either sync mode the shared pin is the sync input.
// - ramp rate down counter on sync clock, loaded each sweep step.
// - with bit 23 clear, reload only when the countdown completes.
// - with bit 23 set, update strobe during sweep restarts the countdown.
// - bit 22 makes each update clear the frequency accumulator one period.
// - bit 21 makes each update clear the phase accumulator one period.
// - bit 20 picks sine when one, cosine when zero.
// - bit 3 slaves the sync clock to the sync input.
// - bit 1 advances sync clock one system clock per sync rising edge.
module dpr_regs #(
    parameter int RR_W = 16
) (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    // decoded register access
    input  wire dpr_pkg::dpr_req_s    req_i,
    output var  logic [63:0]          rdata_o,
    output var  logic                 rdata_valid_o,
    // pins and loop status
    input  wire logic                 pll_lock_i,
    input  wire logic                 lock_sync_i,
    output var  logic                 lock_sync_o,
    output var  logic                 lock_sync_oe_o,
    input  wire logic                 io_update_i,
    // sweep engine side
    input  wire logic                 sweep_active_i,
    input  wire logic [RR_W-1:0]      sweep_ramp_rate_i,
    output var  logic                 sweep_step_o,
    output var  logic                 sync_tick_o,
    // datapath controls
    output var  dpr_pkg::dpr_profile_s profile6_o,
    output var  dpr_pkg::dpr_profile_s profile7_o,
    output var  logic                 sine_select_o,
    output var  logic                 freq_acc_clear_o,
    output var  logic                 phase_acc_clear_o
);
    import dpr_pkg::*;

    logic [PIN_N-1:0]        pin_lvl;
    logic [PIN_N-1:0]        pin_lvl_d_reg;
    logic [CTRL_STORE_W-1:0] ctrl_reg;
    logic                    lock_err_reg;
    logic [SYNC_CNT_W-1:0]   sync_cnt_reg;
    logic [RR_W-1:0]         rr_cnt_reg;

    // pins cross into the register clock through three flops
    dpr_sync3 #(.W(PIN_N), .INIT(PIN_INIT)) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({io_update_i, lock_sync_i, pll_lock_i}),
        .q_o     (pin_lvl)
    );

    // access decode
    wire wr_ctrl  = req_i.wr && (req_i.addr == ADDR_CTRL);
    wire wr_prof6 = req_i.wr && (req_i.addr == ADDR_PROF6);
    wire wr_prof7 = req_i.wr && (req_i.addr == ADDR_PROF7);
    wire rd_ctrl  = req_i.rd && (req_i.addr == ADDR_CTRL);
    wire dpr_profile_s prof_wval = req_i.wdata[PROF_W-1:0];

    // pin edges and loop state
    wire lock_lvl  = pin_lvl[PIN_LOCK];
    wire sync_rise = pin_lvl[PIN_SYNC] && !pin_lvl_d_reg[PIN_SYNC];
    wire upd_rise  = pin_lvl[PIN_UPD] && !pin_lvl_d_reg[PIN_UPD];

    // pin role; manual mode wins if both sync modes are set
    wire dpr_pin_mode_e pin_mode =
        ctrl_reg[BIT_HW_SYNC]   ? PIN_SYNC_MANUAL :
        ctrl_reg[BIT_AUTO_SYNC] ? PIN_SYNC_AUTO : PIN_LOCK_OUT;

    // register read mux; bits above 24 (control) or 61 (profiles) and unmapped addresses read zero
    wire [REG_W-1:0] ctrl_word = REG_W'({lock_err_reg, ctrl_reg});
    wire [REG_W-1:0] rd_word =
        (req_i.addr == ADDR_CTRL)  ? ctrl_word :
        (req_i.addr == ADDR_PROF6) ? REG_W'(profile6_o) :
        (req_i.addr == ADDR_PROF7) ? REG_W'(profile7_o) : '0;

    // set beats the readback clear so no loss of lock goes unseen
    wire lock_err_next = !lock_lvl || (lock_err_reg && !rd_ctrl);

    // sync clock phase counter; carry out marks a sync clock rising edge
    logic       auto_align;
    logic [1:0] sync_inc;
    logic [2:0] sync_sum;
    always_comb begin
        auto_align = (pin_mode == PIN_SYNC_AUTO) && sync_rise;
        sync_inc   = SYNC_STEP;
        if (((pin_mode == PIN_SYNC_MANUAL) && sync_rise) ||
            (wr_ctrl && req_i.wdata[BIT_SW_SYNC])) begin
            sync_inc = SYNC_ADV;
        end
        sync_sum = {1'b0, sync_cnt_reg} + {1'b0, sync_inc};
    end
    wire [SYNC_CNT_W-1:0] sync_cnt_next =
        auto_align ? SYNC_ZERO : sync_sum[SYNC_CNT_W-1:0];
    wire sync_tick_next = auto_align || sync_sum[SYNC_CNT_W];

    // ramp rate countdown
    wire rr_upd_reload = upd_rise && ctrl_reg[BIT_RR_RELOAD] &&
                         sweep_active_i;
    wire rr_done = sync_tick_o && sweep_active_i &&
                   (rr_cnt_reg == '0);
    wire [RR_W-1:0] rr_cnt_next =
        (rr_upd_reload || rr_done)        ? sweep_ramp_rate_i :
        (sync_tick_o && sweep_active_i)   ? rr_cnt_reg - 1'b1 :
                                            rr_cnt_reg;

    // control and profile storage; bit 24 and bit 2 are not stored
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg   <= CTRL_RESET;
            profile6_o <= PROF_RESET;
            profile7_o <= PROF_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= req_i.wdata[CTRL_STORE_W-1:0] &
                            ~(CTRL_STORE_W'(1) << BIT_SW_SYNC);
            end
            if (wr_prof6) begin
                profile6_o <= prof_wval;
            end
            if (wr_prof7) begin
                profile7_o <= prof_wval;
            end
        end
    end

    // readback port and lock flag
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o       <= '0;
            rdata_valid_o <= 1'b0;
            lock_err_reg  <= 1'b0;
        end else begin
            rdata_valid_o <= req_i.rd;
            if (req_i.rd) begin
                rdata_o <= rd_word;
            end
            lock_err_reg <= lock_err_next;
        end
    end

    // shared pin, sync clock and ramp counter
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_lvl_d_reg  <= PIN_INIT;
            lock_sync_o    <= 1'b0;
            lock_sync_oe_o <= 1'b0;
            sync_cnt_reg   <= SYNC_ZERO;
            sync_tick_o    <= 1'b0;
            rr_cnt_reg     <= '0;
            sweep_step_o   <= 1'b0;
            sine_select_o  <= 1'b0;
        end else begin
            pin_lvl_d_reg  <= pin_lvl;
            lock_sync_o    <= lock_lvl;
            lock_sync_oe_o <= (pin_mode == PIN_LOCK_OUT);
            sync_cnt_reg   <= sync_cnt_next;
            sync_tick_o    <= sync_tick_next;
            rr_cnt_reg     <= rr_cnt_next;
            sweep_step_o   <= rr_done;
            sine_select_o  <= ctrl_reg[BIT_SINE];
        end
    end

    // auto-clear pulses, one sync clock period long, per accumulator
    wire [1:0] ac_trig = {upd_rise && ctrl_reg[BIT_AC_PHASE],
                          upd_rise && ctrl_reg[BIT_AC_FREQ]};
    logic [1:0] ac_out;
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ac
            logic                  clr_reg;
            logic [SYNC_CNT_W-1:0] cnt_reg;
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    clr_reg <= 1'b0;
                    cnt_reg <= SYNC_ZERO;
                end else if (ac_trig[c]) begin
                    clr_reg <= 1'b1;
                    cnt_reg <= SYNC_LAST;
                end else if (clr_reg) begin
                    clr_reg <= (cnt_reg != SYNC_ZERO);
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end
            assign ac_out[c] = clr_reg;
        end
    endgenerate
    assign freq_acc_clear_o  = ac_out[0];
    assign phase_acc_clear_o = ac_out[1];

    // checks
    a_prof_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_prof6 |=> profile6_o == $past(prof_wval))
        else $error("profile six did not take the written value");
    a_lock_err_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !lock_lvl |=> lock_err_reg)
        else $error("lock error not set on loss of lock");
    a_lock_err_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        lock_err_reg && !rd_ctrl |=> lock_err_reg)
        else $error("lock error dropped without a readback");
    a_lock_read_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_ctrl && lock_lvl && $past(lock_lvl) |=> !lock_err_reg)
        else $error("readback did not clear lock error while locked");
    a_pin_as_input: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ctrl_reg[BIT_AUTO_SYNC] || ctrl_reg[BIT_HW_SYNC]) |=> !lock_sync_oe_o)
        else $error("shared pin driven while in a sync mode");
    a_ramp_step_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rr_done && !rr_upd_reload |=>
            rr_cnt_reg == $past(sweep_ramp_rate_i) && sweep_step_o)
        else $error("ramp counter not reloaded at end of step");
    a_ramp_no_reload: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !ctrl_reg[BIT_RR_RELOAD] && sweep_active_i && sync_tick_o &&
        rr_cnt_reg != '0 |=> rr_cnt_reg == $past(rr_cnt_reg) - 1'b1)
        else $error("ramp countdown disturbed mid step");
    a_ramp_upd_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rr_upd_reload |=> rr_cnt_reg == $past(sweep_ramp_rate_i))
        else $error("update strobe did not restart the countdown");
    a_freq_clr_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ac_trig[0] |=> freq_acc_clear_o [*4] ##1
            (!freq_acc_clear_o || $past(ac_trig[0])))
        else $error("frequency clear not one sync period long");
    a_phase_clr_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !ctrl_reg[BIT_AC_PHASE] && !phase_acc_clear_o |=> !phase_acc_clear_o)
        else $error("phase clear fired while disabled");
    a_sine_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_ctrl |=> ##1 sine_select_o == $past(req_i.wdata[BIT_SINE], 2))
        else $error("sine select does not follow bit 20");
    a_auto_align: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        auto_align |=> sync_cnt_reg == SYNC_ZERO && sync_tick_o)
        else $error("sync clock not aligned to sync input");
    a_manual_adv: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pin_mode == PIN_SYNC_MANUAL && sync_rise |=>
            sync_cnt_reg == $past(sync_cnt_reg) + SYNC_ADV)
        else $error("sync clock not advanced by one system clock");
endmodule
`default_nettype wire

// file: tb/dpr_host.sv
// host model issuing decoded register accesses into the bank
`timescale 1ns/1ps
`default_nettype none
module dpr_host
    import dpr_pkg::*;
(
    // clock
    input  wire logic        clk_i,
    // access out, answer in
    output var  dpr_req_s    req_o,
    input  wire logic [63:0] rdata_i,
    input  wire logic        rdata_valid_i
);
    initial req_o = '0;

    // whole-word write; bits above 24 (control) or 61 (profiles) forced low
    task automatic wr(input logic [4:0] a, input logic [63:0] d);
        logic [63:0] w;
        w = (a == ADDR_CTRL) ? {32'h0, 7'h00, d[24:0]}
                             : {2'h0, d[61:0]};
        @(posedge clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
        @(posedge clk_i);
        req_o.wr <= 1'b0;
    endtask

    // read pulse, then wait a bounded time for the answer
    task automatic rd(input logic [4:0] a, output logic [63:0] d,
                      output bit ok);
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 64'h0};
        @(posedge clk_i);
        req_o.rd <= 1'b0;
        ok = 1'b0;
        d = 64'h0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge clk_i);
            if (rdata_valid_i === 1'b1) begin
                ok = 1'b1;
                d = rdata_i;
            end
        end
    endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the profile and control register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dpr_pkg::*;
    logic clk_i, rst_n_i, pll_lock_i, lock_sync_i, io_update_i, sweep_active_i;
    logic [15:0] rr;
    dpr_req_s req;
    logic [63:0] rdata;
    logic rvalid, lso, lsoe, step, tick, sine, fclr, pclr;
    dpr_profile_s p6, p7;
    logic [63:0] mdl [int];
    logic [31:0] lfsr_q = 32'h83f321c6;
    int n_errors = 0;
    int checks_done = 0;
    int g0, g, x, nf, np, n3, last;
    logic [39:0] tk;

    dpr_regs #(.RR_W(16)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .req_i(req), .rdata_o(rdata), .rdata_valid_o(rvalid),
        .pll_lock_i(pll_lock_i), .lock_sync_i(lock_sync_i),
        .lock_sync_o(lso), .lock_sync_oe_o(lsoe), .io_update_i(io_update_i),
        .sweep_active_i(sweep_active_i), .sweep_ramp_rate_i(rr),
        .sweep_step_o(step), .sync_tick_o(tick), .profile6_o(p6),
        .profile7_o(p7), .sine_select_o(sine), .freq_acc_clear_o(fclr),
        .phase_acc_clear_o(pclr));
    dpr_host u_host (.clk_i(clk_i), .req_o(req), .rdata_i(rdata),
        .rdata_valid_i(rvalid));

    // 50 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    function logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0], ^(lfsr_q & 32'h80200003)};
        return lfsr_q;
    endfunction

    task final_report();
        if (n_errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task chk(input logic [63:0] s, input logic [63:0] e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    // read through the host and compare with the expected word
    task rdchk(input logic [4:0] a, input logic [63:0] e);
        logic [63:0] d;
        bit ok;
        u_host.rd(a, d, ok);
        chk(64'(ok), 64'h1);
        chk(d, e);
    endtask

    // update pin pulse wide enough to pass the input filter
    task pulse_upd();
        @(posedge clk_i);
        io_update_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        io_update_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    // sync pin pulse; one bit per cycle records each sync tick seen
    task sync_edge(output logic [39:0] t);
        t = '0;
        fork
            begin
                @(posedge clk_i);
                lock_sync_i <= 1'b1;
                repeat (4) @(posedge clk_i);
                lock_sync_i <= 1'b0;
            end
            for (int c = 0; c < 40; c++) begin
                @(negedge clk_i);
                t[c] = (tick === 1'b1);
            end
        join
    endtask

    // cycles until the next sweep step; a hang ends the run
    task next_step(output int n);
        int i;
        for (i = 1; i < 600; i++) begin
            @(negedge clk_i);
            if (step === 1'b1) break;
        end
        n = i;
        if (i == 600) begin
            n_errors++;
            final_report();
        end
    endtask

    initial begin
        rst_n_i = 1'b0;
        pll_lock_i = 1'b1;
        lock_sync_i = 1'b0;
        io_update_i = 1'b0;
        sweep_active_i = 1'b0;
        rr = 16'h0004;
        mdl[ADDR_CTRL] = 64'h0;
        mdl[ADDR_PROF6] = 64'h0;
        mdl[ADDR_PROF7] = 64'h0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // reset values, then random profile contents back to back
        foreach (mdl[a]) rdchk(5'(a), mdl[a]);
        for (int k = 0; k < 6; k++) begin
            x = k % 2 ? ADDR_PROF7 : ADDR_PROF6;
            mdl[x] = {rnd(), rnd()} & 64'h3fffffffffffffff;
            u_host.wr(5'(x), mdl[x]);
            rdchk(5'(x), mdl[x]);
            chk({2'h0, k % 2 ? p7 : p6}, mdl[x]);
        end
        // unmapped place: ignored on write, zero on read
        u_host.wr(5'h1f, {rnd(), rnd()});
        rdchk(5'h1f, 64'h0);
        rdchk(ADDR_PROF6, mdl[ADDR_PROF6]);
        // sine select; bit 24 writes are ignored, bit 2 reads back zero
        for (int s = 0; s < 2; s++) begin
            u_host.wr(ADDR_CTRL, 64'h1000004 | 64'(s) << 20);
            rdchk(ADDR_CTRL, 64'(s) << 20);
            chk(64'(sine), 64'(s));
            chk(64'(lsoe), 64'h1);
        end
        // either sync mode takes the pin away from the lock output
        u_host.wr(ADDR_CTRL, 64'h8);
        repeat (3) @(posedge clk_i);
        chk(64'(lsoe), 64'h0);
        // auto mode: filtered sync edge restarts the sync clock with a tick
        sync_edge(tk);
        chk(64'(tk[10:6]), 64'h11);
        u_host.wr(ADDR_CTRL, 64'h2);
        repeat (3) @(posedge clk_i);
        chk(64'(lsoe), 64'h0);
        // manual sync edge shortens exactly one sync period by a clock
        sync_edge(tk);
        n3 = 0;
        last = -1;
        for (int c = 0; c < 40; c++) begin
            if (tk[c]) begin
                if (last >= 0 && c - last == 3) n3++;
                last = c;
            end
        end
        chk(64'(n3), 64'h1);
        // lock loss is held across relock, cleared by the read
        u_host.wr(ADDR_CTRL, 64'h0);
        rdchk(ADDR_CTRL, 64'h0);
        @(posedge clk_i);
        pll_lock_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk(64'(lso), 64'h0);
        pll_lock_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk(64'(lso), 64'h1);
        rdchk(ADDR_CTRL, 64'h1000000);
        rdchk(ADDR_CTRL, 64'h0);
        // every combination of the two auto-clear bits
        for (int m = 0; m < 4; m++) begin
            u_host.wr(ADDR_CTRL, 64'(m) << 21);
            nf = 0;
            np = 0;
            fork
                pulse_upd();
                for (int c = 0; c < 20; c++) begin
                    @(negedge clk_i);
                    nf += int'(fclr === 1'b1);
                    np += int'(pclr === 1'b1);
                end
            join
            chk(64'(nf), m[1] ? 64'h4 : 64'h0);
            chk(64'(np), m[0] ? 64'h4 : 64'h0);
        end
        // ramp countdown: update restarts it only with bit 23 set
        u_host.wr(ADDR_CTRL, 64'h0);
        @(posedge clk_i);
        rr <= 16'(rnd() % 4) + 16'h0005;
        sweep_active_i <= 1'b1;
        next_step(x);
        next_step(x);
        next_step(g0);
        for (int b = 0; b < 2; b++) begin
            u_host.wr(ADDR_CTRL, 64'(b) << 23);
            next_step(x);
            fork
                next_step(g);
                begin
                    repeat (6) @(posedge clk_i);
                    pulse_upd();
                end
            join
            if (b == 0) chk(64'(g), 64'(g0));
            else chk(64'(g > g0), 64'h1);
        end
        final_report();
    end
endmodule
`default_nettype wire
